/* src/uesc_top.sv */
// Purpose: error flags, interrupt, control bits, frame start and resume for a usb module
// Assumes: events arrive synchronous to CORE_CLK; AXI4-Lite register slave
// Notes: one write and one read outstanding at most; write answers one cycle after taking, read on the taking edge
`include "uesc_cfg.svh"

// Functional notes
// - bit stuffing violation sets flag bit 7
// - invalid descriptor or buffer address sets bit 6
// - late grant or truncated packet sets bit 5
// - over sixteen idle bit times sets bit 4
// - partial byte data field sets bit 3
// - crc16 failure rejects packet, sets bit 2
// - bit 1: host end-of-frame, device crc5
// - flags hardware-set, reset zero, write-one clears
// - flag register upper 24 bits read zero
// - pingpong reset returns pointers to even bank
// - device mode: bit 0 enables module
// - host mode: bit 0 sends frame start each ms
// - host-mode bit change resets host logic
// - host resume release appends low-speed end-of-packet
module uesc_top
  import uesc_pkg::*;
#(
  parameter int SOF_CYC = `UESC_SOF_NS / `UESC_CLK_NS, // cycles per frame
  parameter int SOF_W = 18                            // frame counter width
) (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire uesc_evt_s EV_IN,
  input wire logic TOKEN_BUSY,
  output logic PKT_REJECT,
  output logic MODULE_EN,
  output logic SOF_TOKEN,
  output logic PP_PTR_RESET,
  output logic HOST_LOGIC_RST,
  output logic RESUME_DRIVE,
  output logic LS_EOP_REQ,
  output logic ERR_IRQ
);

  localparam logic [SOF_W-1:0] SOF_LAST = SOF_W'(SOF_CYC - 1); // reload value

  // register bus state
  logic aw_have_q;          // write address held
  logic [7:0] aw_addr_q;    // held write address
  logic w_have_q;           // write data held
  logic [31:0] w_data_q;    // held write data
  logic [3:0] w_strb_q;     // held byte strobes
  logic bvalid_q;           // write answer pending
  logic [1:0] bresp_q;      // write answer code
  logic rvalid_q;           // read answer pending
  logic [1:0] rresp_q;      // read answer code
  logic [31:0] rdata_q;     // read answer data
  logic wr_fire;            // write performed this cycle
  logic rd_take;            // read address taken

  // block state
  logic [7:0] flags_q;      // sticky error flags
  logic [7:0] flags_d;      // next flags
  logic [7:0] enable_q;     // interrupt enables
  logic [3:0] ctl_q;        // control bits
  logic [7:0] set_vec;      // hardware set requests
  logic [7:0] clr_vec;      // software clear requests
  logic host_q;             // host mode delayed, for change detect
  logic [4:0] tmo_cnt_q;    // bit times since end of packet
  logic tmo_arm_q;          // waiting for response
  logic tmo_hit;            // turnaround time-out now
  logic [SOF_W-1:0] sof_cnt_q; // frame counter
  logic sof_zero;           // frame counter at zero
  logic eof_hit;            // end-of-frame error now
  logic resume_q;           // resume bit delayed
  logic [3:0] eop_cnt_q;    // low-speed eop length
  uesc_rs_e rs_q;           // resume state
  logic host_mode;          // operating as host
  logic ctl_en;             // enable bit of control

  // byte lane write of an 8-bit field
  function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] d,
                                       input logic [3:0] s);
    lane0 = s[0] ? d[7:0] : old;
  endfunction : lane0

  // address is one of the four registers
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `UESC_OFS_FLAGS) || (a == `UESC_OFS_ENABLE) ||
             (a == `UESC_OFS_CLEAR) || (a == `UESC_OFS_CONTROL);
  endfunction : mapped

  assign host_mode = ctl_q[`UESC_C_HOST];
  assign ctl_en = ctl_q[`UESC_C_EN];

  // ---------------- axi4-lite slave ----------------
  assign S_AXI_AWREADY = !aw_have_q && !bvalid_q;
  assign S_AXI_WREADY = !w_have_q && !bvalid_q;
  assign S_AXI_ARREADY = !rvalid_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RRESP = rresp_q;
  assign S_AXI_RDATA = rdata_q;
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign rd_take = S_AXI_ARVALID && !rvalid_q;

  // write address capture, either order with data
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= S_AXI_AWADDR;
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
    end
  end

  // write data capture
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      w_have_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_have_q <= 1'b1;
      w_data_q <= S_AXI_WDATA;
      w_strb_q <= S_AXI_WSTRB;
    end else if (wr_fire) begin
      w_have_q <= 1'b0;
    end
  end

  // write answer, held until taken
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      bvalid_q <= 1'b0;
      bresp_q <= `UESC_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= mapped(aw_addr_q) ? `UESC_RESP_OKAY : `UESC_RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_q <= 1'b0;
    end
  end

  // read answer; upper bits always zero
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      rvalid_q <= 1'b0;
      rresp_q <= `UESC_RESP_OKAY;
      rdata_q <= `UESC_RD_ZERO;
    end else if (rd_take) begin
      rvalid_q <= 1'b1;
      rresp_q <= mapped(S_AXI_ARADDR) ? `UESC_RESP_OKAY : `UESC_RESP_SLVERR;
      rdata_q <= `UESC_RD_ZERO;
      unique case (S_AXI_ARADDR)
        `UESC_OFS_FLAGS: rdata_q[7:0] <= flags_q;
        `UESC_OFS_ENABLE: rdata_q[7:0] <= enable_q;
        `UESC_OFS_CONTROL: begin
          rdata_q[3:0] <= ctl_q;
          rdata_q[`UESC_C_TOKBUSY] <= TOKEN_BUSY;
        end
        default: rdata_q <= `UESC_RD_ZERO; // clear register and holes read zero
      endcase
    end else if (S_AXI_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  // ---------------- error flags ----------------
  // turnaround watch: count bit times after an end of packet
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      tmo_arm_q <= 1'b0;
      tmo_cnt_q <= 5'h00;
    end else if (EV_IN.eop_seen) begin
      tmo_arm_q <= 1'b1;
      tmo_cnt_q <= 5'h00;
    end else if (EV_IN.resp_seen || tmo_hit) begin
      tmo_arm_q <= 1'b0;
    end else if (tmo_arm_q && EV_IN.bit_tick) begin
      tmo_cnt_q <= tmo_cnt_q + 5'h01;
    end
  end

  // seventeenth idle bit time is more than sixteen
  assign tmo_hit = tmo_arm_q && EV_IN.bit_tick && !EV_IN.resp_seen &&
                   (tmo_cnt_q == `UESC_TMO_BITS);
  assign eof_hit = host_mode && sof_zero && EV_IN.xmit_active;

  // hardware set sources per flag
  always_comb begin
    set_vec = 8'h00;
    set_vec[`UESC_B_STUFF] = EV_IN.bit_stuff;
    set_vec[`UESC_B_BMX] = EV_IN.bmx_addr;
    set_vec[`UESC_B_DMA] = EV_IN.dma_late || EV_IN.dma_trunc;
    set_vec[`UESC_B_TMO] = tmo_hit;
    set_vec[`UESC_B_PART] = EV_IN.part_byte;
    set_vec[`UESC_B_CRC16] = EV_IN.crc16_bad;
    set_vec[`UESC_B_SHARED] = host_mode ? eof_hit : EV_IN.crc5_bad;
    set_vec[`UESC_B_PID] = EV_IN.pid_bad;
  end

  // write of ones to flags or clear register clears; zeros leave flags alone
  always_comb begin
    clr_vec = 8'h00;
    if (wr_fire && w_strb_q[0] &&
        (aw_addr_q == `UESC_OFS_FLAGS || aw_addr_q == `UESC_OFS_CLEAR)) begin
      clr_vec = w_data_q[7:0];
    end
    flags_d = (flags_q & ~clr_vec) | set_vec; // set wins over clear
  end

  // sticky flag storage
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      flags_q <= `UESC_FLAGS_RST;
    end else begin
      flags_q <= flags_d;
    end
  end

  // crc16 failure rejects the packet
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      PKT_REJECT <= 1'b0;
    end else begin
      PKT_REJECT <= EV_IN.crc16_bad;
    end
  end

  // interrupt enables
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      enable_q <= `UESC_ENABLE_RST;
    end else if (wr_fire && aw_addr_q == `UESC_OFS_ENABLE) begin
      enable_q <= lane0(enable_q, w_data_q, w_strb_q);
    end
  end

  assign ERR_IRQ = |(flags_q & enable_q);

  // ---------------- control ----------------
  // control register write
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      ctl_q <= `UESC_CTL_RST;
    end else if (wr_fire && aw_addr_q == `UESC_OFS_CONTROL && w_strb_q[0]) begin
      ctl_q <= w_data_q[3:0];
    end
  end

  // registered control outputs
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      MODULE_EN <= 1'b0;
      PP_PTR_RESET <= 1'b0;
      host_q <= 1'b0;
      HOST_LOGIC_RST <= 1'b0;
    end else begin
      MODULE_EN <= ctl_en && !host_mode;
      PP_PTR_RESET <= ctl_q[`UESC_C_PPRST];
      host_q <= host_mode;
      HOST_LOGIC_RST <= host_q != host_mode; // either direction
    end
  end

  assign sof_zero = (sof_cnt_q == SOF_W'(0));

  // frame counter, host logic, reset on mode change
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      sof_cnt_q <= SOF_LAST;
      SOF_TOKEN <= 1'b0;
    end else if (host_q != host_mode || !(host_mode && ctl_en)) begin
      sof_cnt_q <= SOF_LAST;
      SOF_TOKEN <= 1'b0; // no frame starts when disabled
    end else begin
      sof_cnt_q <= sof_zero ? SOF_LAST : sof_cnt_q - SOF_W'(1);
      SOF_TOKEN <= sof_zero; // one token per frame period
    end
  end

  // resume signalling; software times the hold
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      rs_q <= RS_IDLE;
      resume_q <= 1'b0;
      eop_cnt_q <= 4'h0;
    end else begin
      resume_q <= ctl_q[`UESC_C_RESUME];
      unique case (rs_q)
        RS_IDLE: begin
          if (ctl_q[`UESC_C_RESUME]) begin
            rs_q <= RS_DRIVE;
          end
        end
        RS_DRIVE: begin
          if (!ctl_q[`UESC_C_RESUME]) begin
            rs_q <= host_mode ? RS_EOP : RS_IDLE;
            eop_cnt_q <= `UESC_LSEOP_CYC;
          end
        end
        RS_EOP: begin
          eop_cnt_q <= eop_cnt_q - 4'h1;
          if (eop_cnt_q == 4'h1) begin
            rs_q <= RS_IDLE;
          end
        end
        default: rs_q <= RS_IDLE;
      endcase
    end
  end

  assign RESUME_DRIVE = rs_q == RS_DRIVE;
  assign LS_EOP_REQ = rs_q == RS_EOP;

  // ---------------- checks ----------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_eop_then_quiet;
    EV_IN.eop_seen ##1 (!EV_IN.resp_seen && !EV_IN.eop_seen) [*8];
  endsequence

  sequence s_resume_release;
    (rs_q == RS_DRIVE) && !ctl_q[`UESC_C_RESUME] && host_mode;
  endsequence

  AST_STUFF_SET: assert property (EV_IN.bit_stuff |=> flags_q[`UESC_B_STUFF])
    else $error("bit stuff event did not set flag");
  AST_BMX_SET: assert property (EV_IN.bmx_addr |=> flags_q[`UESC_B_BMX])
    else $error("address error did not set flag");
  AST_DMA_SET: assert property ((EV_IN.dma_late || EV_IN.dma_trunc) |=>
                                flags_q[`UESC_B_DMA])
    else $error("memory access error did not set flag");
  AST_TMO_SET: assert property (tmo_hit |=> flags_q[`UESC_B_TMO] && !tmo_arm_q)
    else $error("turnaround timeout not flagged");
  AST_TMO_NOT_EARLY: assert property (s_eop_then_quiet |-> !tmo_hit)
    else $error("turnaround timeout too early");
  AST_PART_SET: assert property (EV_IN.part_byte |=> flags_q[`UESC_B_PART])
    else $error("partial byte did not set flag");
  AST_CRC16_REJ: assert property (EV_IN.crc16_bad |=> PKT_REJECT &&
                                  flags_q[`UESC_B_CRC16])
    else $error("crc16 failure not rejected");
  AST_SHARED_DEV: assert property (!host_mode && EV_IN.crc5_bad |=>
                                   flags_q[`UESC_B_SHARED])
    else $error("token crc error not flagged");
  AST_W1C_HOLD: assert property (flags_q[`UESC_B_PID] && !clr_vec[`UESC_B_PID] |=>
                                 flags_q[`UESC_B_PID])
    else $error("flag lost without a one written");
  AST_UPPER_ZERO: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000)
    else $error("upper flag bits not zero");
  AST_PPRST: assert property (ctl_q[`UESC_C_PPRST] |=> PP_PTR_RESET)
    else $error("pingpong reset not forwarded");
  AST_DEV_EN: assert property (ctl_en && !host_mode |=> MODULE_EN)
    else $error("module not enabled in device mode");
  AST_SOF_PERIOD: assert property (SOF_TOKEN |=> !SOF_TOKEN [*2])
    else $error("frame start tokens too close");
  AST_HOST_RST: assert property ($changed(host_mode) |=> HOST_LOGIC_RST)
    else $error("host logic reset missing on mode change");
  AST_LSEOP: assert property (s_resume_release |=> LS_EOP_REQ [*2])
    else $error("low-speed end of packet not appended");
  AST_IRQ: assert property ((flags_q & enable_q) != 8'h00 |-> ERR_IRQ)
    else $error("enabled flag without interrupt");

endmodule : uesc_top

/* src/uesc_cfg.svh */
// Purpose: constants for the usb error status and control block
// Assumes: 32-bit register bus, 200 MHz core clock
// Notes: byte addresses, bit positions, reset values and timing figures
`ifndef UESC_CFG_SVH
`define UESC_CFG_SVH

// register byte addresses
`define UESC_OFS_FLAGS 8'h00
`define UESC_OFS_ENABLE 8'h04
`define UESC_OFS_CLEAR 8'h08
`define UESC_OFS_CONTROL 8'h0C

// error flag positions
`define UESC_B_STUFF 7
`define UESC_B_BMX 6
`define UESC_B_DMA 5
`define UESC_B_TMO 4
`define UESC_B_PART 3
`define UESC_B_CRC16 2
`define UESC_B_SHARED 1
`define UESC_B_PID 0

// control register positions
`define UESC_C_EN 0
`define UESC_C_PPRST 1
`define UESC_C_RESUME 2
`define UESC_C_HOST 3
`define UESC_C_TOKBUSY 5

// reset values and widths
`define UESC_FLAGS_RST 8'h00
`define UESC_ENABLE_RST 8'h00
`define UESC_CTL_RST 4'h0
`define UESC_RD_ZERO 32'h0000_0000

// axi responses
`define UESC_RESP_OKAY 2'b00
`define UESC_RESP_SLVERR 2'b10

// timing
`define UESC_CLK_NS 5
`define UESC_SOF_NS 1000000
`define UESC_TMO_BITS 5'h10
`define UESC_LSEOP_CYC 4'h8

`endif

/* src/uesc_pkg.sv */
// Purpose: types for the usb error status and control block
// Assumes: included config header holds all numbers
// Notes: event carrier and resume state encoding
package uesc_pkg;

  // hardware events from the usb engine, one-cycle pulses except xmit_active
  typedef struct packed {
    logic bit_stuff;    // packet failed bit stuffing
    logic bmx_addr;     // descriptor table or buffer address invalid
    logic dma_late;     // memory bus grant too late
    logic dma_trunc;    // packet longer than its buffer
    logic part_byte;    // data field not a whole number of bytes
    logic crc16_bad;    // data crc failed
    logic crc5_bad;     // token crc failed
    logic pid_bad;      // packet id check failed
    logic eop_seen;     // end of packet on the bus
    logic resp_seen;    // expected response started
    logic bit_tick;     // one bit time elapsed
    logic xmit_active;  // engine transmitting or receiving (level)
  } uesc_evt_s;

  // resume signalling states, one-hot
  typedef enum logic [2:0] {
    RS_IDLE = 3'b001,
    RS_DRIVE = 3'b010,
    RS_EOP = 3'b100
  } uesc_rs_e;

endpackage : uesc_pkg

/* tb/uesc_usb_model.sv */
// Purpose: usb engine stand-in that raises error and bus event pulses
// Assumes: bench drives the requests just after rising clock edges
// Notes: idle gaps tick every cycle, or every second cycle when slow
module uesc_usb_model
  import uesc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] err_go,
  input wire logic gap_go,
  input wire logic [4:0] gap_len,
  input wire logic gap_resp,
  input wire logic slow,
  input wire logic xmit,
  output uesc_evt_s ev
);
  logic [4:0] left_q; // idle bit times still to give
  logic ph_q; // phase of the slow pace

  // one process makes every event, all pulses last one cycle
  always_ff @(posedge clk) begin
    ev <= '0;
    ev.xmit_active <= xmit;
    ph_q <= ~ph_q;
    if (!rst_n) begin
      left_q <= '0;
      ph_q <= 1'b0;
    end else if (gap_go) begin
      ev.eop_seen <= 1'b1; // idle gap starts at end of packet
      left_q <= gap_len;
    end else begin
      ev[11:4] <= err_go; // error pulses in struct order
      if (left_q != 5'h00 && (!slow || ph_q)) begin
        ev.bit_tick <= 1'b1; // one idle bit time
        left_q <= left_q - 5'h01;
        if (gap_resp && left_q == 5'h0C) begin
          ev.resp_seen <= 1'b1; // answer arrives in time
        end
      end
    end
  end
endmodule : uesc_usb_model

/* tb/testbench.sv */
// Purpose: self-checking bench for the usb error status and control block
// Assumes: AXI4-Lite master here, usb engine model beside the block
// Notes: frame length shortened to 20 cycles; reads checked from a queue
module testbench import uesc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  `include "uesc_cfg.svh"
  localparam int SOFN = 20; // shortened frame length
  logic clk = 1'b0, rst_n = 1'b0;
  logic [7:0] awaddr = '0, araddr = '0, err_go = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] wstrb = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic tok_busy = 0, gap_go = 0, gap_resp = 0, slow = 0, xmit = 0;
  logic [4:0] gap_len = '0;
  logic pkt_rej, mod_en, sof, pp_rst, host_rst, res_drv, ls_eop, irq, crc_q = 0;
  uesc_evt_s ev;
  int n_mismatch = 0, check_count = 0, n_hrst = 0, n_eop = 0, n_sof = 0;
  int i, t, h0, s0;
  logic [33:0] rq[$]; // expected read response and data
  logic [1:0] bq[$]; // expected write responses
  logic [7:0] m, fb;
  logic [7:0] fmap [8] = '{8'h80, 8'h40, 8'h20, 8'h20, 8'h08, 8'h04, 8'h02, 8'h01};

  // clock at 200 MHz
  always #2.5 clk = ~clk;

  uesc_usb_model i_uesc_usb_model (.clk(clk), .rst_n(rst_n), .err_go(err_go),
    .gap_go(gap_go), .gap_len(gap_len), .gap_resp(gap_resp), .slow(slow),
    .xmit(xmit), .ev(ev));

  uesc_top #(.SOF_CYC(SOFN), .SOF_W(18)) i_uesc_top (.CORE_CLK(clk), .RESET_N(rst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .EV_IN(ev), .TOKEN_BUSY(tok_busy),
    .PKT_REJECT(pkt_rej), .MODULE_EN(mod_en), .SOF_TOKEN(sof), .PP_PTR_RESET(pp_rst),
    .HOST_LOGIC_RST(host_rst), .RESUME_DRIVE(res_drv), .LS_EOP_REQ(ls_eop),
    .ERR_IRQ(irq));

  // compare one value and count it
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] s);
    check_count++;
    if (e !== s) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // final counts and verdict
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // one register write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    bq.push_back(er);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (k == 40) n_mismatch++;
    bready <= 1'b0;
    @(posedge clk);
  endtask : wr

  // one register read, expectation noted for the monitor
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int k;
    rq.push_back({er, ed});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (k == 40) n_mismatch++;
    rready <= 1'b0;
    @(posedge clk);
  endtask : rd

  // fire error events for one cycle
  task automatic pulse(input logic [7:0] e);
    err_go <= e;
    @(posedge clk);
    err_go <= '0;
    cyc(3);
  endtask : pulse

  // monitor takes the oldest note whenever a result appears
  always @(posedge clk) begin
    if (rvalid && rready) chk("read", rq.pop_front(), {rresp, rdata});
    if (bvalid && bready) chk("bresp", {32'h0, bq.pop_front()}, {32'h0, bresp});
    if (crc_q || pkt_rej) chk("reject", {33'h0, crc_q}, {33'h0, pkt_rej});
    crc_q <= ev.crc16_bad;
    n_hrst += host_rst;
    n_eop += ls_eop;
    n_sof += sof;
  end

  // watchdog against a hang
  initial begin
    #(5ns * 20000);
    n_mismatch++;
    wrap_up();
  end

  initial begin
    void'($urandom(87582));
    cyc(3);
    rst_n <= 1'b1;
    for (i = 0; i < 4; i++) rd(8'(4 * i), 0, `UESC_RESP_OKAY);
    rd(8'h10, 0, `UESC_RESP_SLVERR);
    wr(8'h10, $urandom, `UESC_RESP_SLVERR);
    // each event sets its flag, zero write keeps it, one write clears it
    for (i = 0; i < 8; i++) begin
      fb = fmap[i];
      pulse(8'h80 >> i);
      rd(`UESC_OFS_FLAGS, 32'(fb), `UESC_RESP_OKAY);
      wr(`UESC_OFS_FLAGS, $urandom & ~32'(fb), `UESC_RESP_OKAY);
      rd(`UESC_OFS_FLAGS, 32'(fb), `UESC_RESP_OKAY);
      wr(i[0] ? `UESC_OFS_CLEAR : `UESC_OFS_FLAGS, 32'(fb), `UESC_RESP_OKAY);
      rd(`UESC_OFS_FLAGS, 0, `UESC_RESP_OKAY);
    end
    // interrupt raised, masked and cleared
    m = 8'($urandom);
    wr(`UESC_OFS_ENABLE, {24'hA5A5A5, m}, `UESC_RESP_OKAY);
    rd(`UESC_OFS_ENABLE, 32'(m), `UESC_RESP_OKAY);
    pulse(8'h04);
    chk("irq", 34'(m[2]), 34'(irq));
    wr(`UESC_OFS_ENABLE, 32'h04, `UESC_RESP_OKAY);
    chk("irq", 34'h1, 34'(irq));
    wr(`UESC_OFS_CLEAR, 32'h04, `UESC_RESP_OKAY);
    chk("irq", 34'h0, 34'(irq));
    // idle gaps: 16 and 17 bit times, then a gap with an answer
    for (i = 0; i < 3; i++) begin
      gap_len <= (i == 0) ? 5'h10 : (i == 1) ? 5'h11 : 5'h14;
      gap_resp <= (i == 2);
      slow <= 1'($urandom);
      gap_go <= 1'b1;
      @(posedge clk);
      gap_go <= 1'b0;
      cyc(50);
      rd(`UESC_OFS_FLAGS, (i == 1) ? 32'h10 : 32'h0, `UESC_RESP_OKAY);
      wr(`UESC_OFS_FLAGS, 32'h10, `UESC_RESP_OKAY);
    end
    // device mode controls and token busy status
    wr(`UESC_OFS_CONTROL, 32'h3, `UESC_RESP_OKAY);
    chk("enable", 34'h1, 34'(mod_en));
    chk("pingpong", 34'h1, 34'(pp_rst));
    tok_busy <= 1'b1;
    rd(`UESC_OFS_CONTROL, 32'h23, `UESC_RESP_OKAY);
    tok_busy <= 1'b0;
    wr(`UESC_OFS_CONTROL, 32'h0, `UESC_RESP_OKAY);
    chk("enable", 34'h0, 34'(mod_en));
    chk("pingpong", 34'h0, 34'(pp_rst));
    // host mode: one reset per change, frame starts every frame length
    h0 = n_hrst;
    wr(`UESC_OFS_CONTROL, 32'h8, `UESC_RESP_OKAY);
    wr(`UESC_OFS_CONTROL, 32'h9, `UESC_RESP_OKAY);
    chk("hostrst", 34'h1, 34'(n_hrst - h0));
    chk("enable", 34'h0, 34'(mod_en));
    for (t = 0; t < 100 && !sof; t++) @(posedge clk);
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (!sof && t < 100);
    chk("sofgap", 34'(SOFN), 34'(t));
    xmit <= 1'b1;
    cyc(2 * SOFN + 2);
    xmit <= 1'b0;
    rd(`UESC_OFS_FLAGS, 32'h02, `UESC_RESP_OKAY);
    wr(`UESC_OFS_FLAGS, 32'h02, `UESC_RESP_OKAY);
    wr(`UESC_OFS_CONTROL, 32'h8, `UESC_RESP_OKAY);
    s0 = n_sof;
    cyc(3 * SOFN);
    chk("sofoff", 34'h0, 34'(n_sof - s0));
    // resume in host mode ends with a low-speed end of packet
    wr(`UESC_OFS_CONTROL, 32'hC, `UESC_RESP_OKAY);
    chk("resume", 34'h1, 34'(res_drv));
    s0 = n_eop;
    wr(`UESC_OFS_CONTROL, 32'h8, `UESC_RESP_OKAY);
    cyc(12);
    chk("lseop", 34'h8, 34'(n_eop - s0));
    chk("resume", 34'h0, 34'(res_drv));
    wr(`UESC_OFS_CONTROL, 32'h0, `UESC_RESP_OKAY);
    cyc(1); // let the monitor count the reset pulse of the last edge first
    chk("hostrst", 34'h2, 34'(n_hrst - h0));
    wr(`UESC_OFS_CONTROL, 32'h4, `UESC_RESP_OKAY);
    wr(`UESC_OFS_CONTROL, 32'h0, `UESC_RESP_OKAY);
    cyc(12);
    chk("lseop", 34'h8, 34'(n_eop - s0));
    wrap_up();
  end
endmodule : testbench
